/* logic/ppir_pkg.sv */
package ppir_pkg;
  // instruction codes presented by the channel
  typedef enum logic [2:0] {
    PPIR_OP_START = 3'h0,
    PPIR_OP_START_FAST = 3'h1,
    PPIR_OP_TEST = 3'h2,
    PPIR_OP_CLEAR = 3'h3,
    PPIR_OP_HALT_IO = 3'h4,
    PPIR_OP_HALT_DEV = 3'h5
  } ppir_op_t;
  localparam logic [1:0] PPIR_CC_0 = 2'h0;
  localparam logic [1:0] PPIR_CC_1 = 2'h1;
  localparam logic [1:0] PPIR_CC_2 = 2'h2;
  localparam logic [1:0] PPIR_CC_3 = 2'h3;
  localparam logic [3:0] PPIR_CHANNEL = 4'h0;
  localparam logic [7:0] PPIR_ADDR_LO = 8'h30;
  localparam logic [7:0] PPIR_ADDR_HI = 8'h3F;
  localparam logic [7:0] PPIR_PAIR_OFFSET = 8'h08;
  localparam int PPIR_UNUSABLE_LINE = 3;
  localparam int PPIR_LINES = 8;
endpackage

/* logic/ppir_line.sv */
`timescale 1ns/10ps
// per-line state: busy and pending interruption for both functions
module ppir_line (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // instruction aimed at this line
  input wire logic sel,
  input wire logic hi_sel,
  input wire logic start_ok,
  input wire logic is_test,
  input wire logic is_stop,
  // functions report
  input wire logic lc_done,
  input wire logic bp_done,
  // state
  output logic busy,
  output logic pend
);
  logic [1:0] busy_q, busy_d;
  logic [1:0] pend_q, pend_d;
  logic idx;
  always_comb begin
    idx = hi_sel;
    busy_d = busy_q;
    pend_d = pend_q;
    // completion raises a pending interruption; set wins over clear
    if (sel && (is_test || is_stop)) begin
      pend_d[idx] = 1'b0;
    end
    if (sel && is_stop) begin
      busy_d[idx] = 1'b0;
    end
    // buffer pool stop also ends link control, whose completion never comes
    if (sel && is_stop && hi_sel) begin
      busy_d[0] = 1'h0; // R9 R11
    end
    if (sel && start_ok) begin
      busy_d[idx] = 1'b1;
    end
    if (lc_done) begin
      busy_d[0] = 1'b0;
      pend_d[0] = 1'b1;
    end
    if (bp_done) begin
      busy_d[1] = 1'b0;
      pend_d[1] = 1'b1;
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 2'h0;
      pend_q <= 2'h0;
    end else begin
      busy_q <= busy_d;
      pend_q <= pend_d;
    end
  end
  assign busy = busy_q[hi_sel];
  assign pend = pend_q[hi_sel];
endmodule // ppir_line

/* logic/ppir_responder.sv */
`timescale 1ns/10ps
// Notes on behaviour
// R1 - answer only on channel zero, addresses 30 through 3F; code raises done for every instruction and sets claimed only in that range
// R2 - line n owns pair 30+n / 38+n; pair 33/3B never serves a port
// R3 - low address goes to link control, high address to buffer pool
// R4 - fast-release start behaves exactly as ordinary start
// R5 - start: 0 initiated, 2 busy or pending, 3 invalid or absent
// R6 - start gets code 1 on bad no-op chain, inline test, or invalid command
// R7 - test: 0 available, 1 status stored and pending cleared, 2 busy, 3 invalid
// R8 - clear stops work, stores status; code 0 or 1, never 2
// R9 - clear to buffer pool address forces port inactive, unit check in link control
// R10 - both halts alike, end work; 0 pending, 1 terminated, 3 invalid, never 2
// R11 - halt to buffer pool address forces port inactive, unit check in link control
// R12 - code is two bits with completion strobe; address validity checked first
module ppir_responder #(
  parameter logic [7:0] INSTALLED = 8'hF7
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // instruction from channel
  input wire logic instr_valid,
  input wire logic [3:0] instr_channel,
  input wire logic [7:0] instr_addr,
  input wire ppir_pkg::ppir_op_t instr_op,
  // first command word qualifiers
  input wire logic noop_no_chain,
  input wire logic cmd_invalid,
  input wire logic inline_test,
  // completion from the line functions
  input wire logic [7:0] lc_done,
  input wire logic [7:0] bp_done,
  // answer to channel
  output logic done,
  output logic claimed,
  output logic [1:0] cond_code,
  output logic status_store,
  // launches and stops to line functions
  output logic [7:0] lc_start,
  output logic [7:0] bp_start,
  output logic [7:0] lc_stop,
  output logic [7:0] bp_stop,
  // port forced inactive with link control unit check
  output logic [7:0] port_inactive,
  output logic [7:0] lc_unit_check
);
  // line 3 has no packet port, so a build that installs it is refused
  if (INSTALLED[ppir_pkg::PPIR_UNUSABLE_LINE]) begin : g_bad_line
    $error("line 3 cannot be installed as a packet port");
  end

  logic in_range, hi, valid;
  logic [2:0] line;
  logic [7:0] sel_vec, busy_vec, pend_vec;
  logic is_start, is_test, is_clear, is_halt, is_stop;
  logic start_ok, cur_busy, cur_pend;
  logic done_d, done_q, claimed_d, claimed_q, store_d, store_q;
  logic [1:0] cc_d, cc_q;
  logic [7:0] lcs_d, lcs_q, bps_d, bps_q, lct_d, lct_q, bpt_d, bpt_q;
  logic [7:0] pin_d, pin_q, uc_d, uc_q;

  always_comb begin
    in_range = instr_valid && (instr_channel == ppir_pkg::PPIR_CHANNEL) &&
               (instr_addr >= ppir_pkg::PPIR_ADDR_LO) &&
               (instr_addr <= ppir_pkg::PPIR_ADDR_HI); // R1
    hi = instr_addr[3]; // R3
    line = instr_addr[2:0]; // R2
    valid = in_range && INSTALLED[line] &&
            (line != 3'(ppir_pkg::PPIR_UNUSABLE_LINE)); // R2
    is_start = (instr_op == ppir_pkg::PPIR_OP_START) ||
               (instr_op == ppir_pkg::PPIR_OP_START_FAST); // R4
    is_test = instr_op == ppir_pkg::PPIR_OP_TEST;
    is_clear = instr_op == ppir_pkg::PPIR_OP_CLEAR;
    is_halt = (instr_op == ppir_pkg::PPIR_OP_HALT_IO) ||
              (instr_op == ppir_pkg::PPIR_OP_HALT_DEV); // R10
    is_stop = is_clear || is_halt;
    sel_vec = valid ? (8'h01 << line) : 8'h00;
  end

  always_comb begin
    cur_busy = busy_vec[line];
    cur_pend = pend_vec[line];
    start_ok = valid && is_start && !cur_busy && !cur_pend &&
               !noop_no_chain && !inline_test && !cmd_invalid;
  end

  genvar g;
  generate
    for (g = 0; g < ppir_pkg::PPIR_LINES; g++) begin : g_line
      ppir_line u_line (
        .clock(clock),
        .sys_rst(sys_rst),
        .sel(sel_vec[g]),
        .hi_sel(hi),
        .start_ok(start_ok),
        .is_test(is_test && !busy_vec[g]),
        .is_stop(is_stop),
        .lc_done(lc_done[g]),
        .bp_done(bp_done[g]),
        .busy(busy_vec[g]),
        .pend(pend_vec[g])
      );
    end
  endgenerate

  always_comb begin
    done_d = instr_valid;
    claimed_d = in_range;
    store_d = 1'b0;
    cc_d = ppir_pkg::PPIR_CC_3;
    lcs_d = 8'h00;
    bps_d = 8'h00;
    lct_d = 8'h00;
    bpt_d = 8'h00;
    pin_d = 8'h00;
    uc_d = 8'h00;
    if (!valid) begin
      cc_d = ppir_pkg::PPIR_CC_3; // R12
    end else if (is_start) begin
      if (cur_busy || cur_pend) begin
        cc_d = ppir_pkg::PPIR_CC_2; // R5
      end else if (noop_no_chain || inline_test || cmd_invalid) begin
        cc_d = ppir_pkg::PPIR_CC_1; // R6
        store_d = 1'b1;
      end else begin
        cc_d = ppir_pkg::PPIR_CC_0; // R5
        lcs_d = hi ? 8'h00 : sel_vec; // R3
        bps_d = hi ? sel_vec : 8'h00; // R3
      end
    end else if (is_test) begin
      if (cur_busy) begin
        cc_d = ppir_pkg::PPIR_CC_2; // R7
      end else if (cur_pend) begin
        cc_d = ppir_pkg::PPIR_CC_1; // R7
        store_d = 1'b1;
      end else begin
        cc_d = ppir_pkg::PPIR_CC_0; // R7
      end
    end else if (is_clear) begin
      // status is stored on every clear; code 1 whenever the addressed function was running or pending
      store_d = 1'b1; // R8
      cc_d = (cur_busy || cur_pend) ? ppir_pkg::PPIR_CC_1 : ppir_pkg::PPIR_CC_0; // R8
      lct_d = hi ? 8'h00 : sel_vec;
      bpt_d = hi ? sel_vec : 8'h00;
    end else if (is_halt) begin
      if (cur_busy) begin
        cc_d = ppir_pkg::PPIR_CC_1; // R10
      end else begin
        cc_d = ppir_pkg::PPIR_CC_0; // R10
      end
      lct_d = hi ? 8'h00 : sel_vec;
      bpt_d = hi ? sel_vec : 8'h00;
    end
    if (valid && hi && is_stop) begin
      // buffer pool stop takes the whole port down
      pin_d = sel_vec; // R9 R11
      uc_d = sel_vec; // R9 R11
      lct_d = sel_vec;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      claimed_q <= 1'b0;
      store_q <= 1'b0;
      cc_q <= 2'h0;
      lcs_q <= 8'h00;
      bps_q <= 8'h00;
      lct_q <= 8'h00;
      bpt_q <= 8'h00;
      pin_q <= 8'h00;
      uc_q <= 8'h00;
    end else begin
      done_q <= done_d;
      claimed_q <= claimed_d;
      store_q <= store_d;
      cc_q <= cc_d;
      lcs_q <= lcs_d;
      bps_q <= bps_d;
      lct_q <= lct_d;
      bpt_q <= bpt_d;
      pin_q <= pin_d;
      uc_q <= uc_d;
    end
  end

  assign done = done_q;
  assign claimed = claimed_q;
  assign cond_code = cc_q; // R12
  assign status_store = store_q;
  assign lc_start = lcs_q;
  assign bp_start = bps_q;
  assign lc_stop = lct_q;
  assign bp_stop = bpt_q;
  assign port_inactive = pin_q;
  assign lc_unit_check = uc_q;

  // assertions
  invalid_cc_three_a: assert property (@(posedge clock) disable iff (sys_rst) // R1
    (instr_valid && !valid) |=> (done && cond_code == 2'h3))
    else $error("invalid address not answered with code 3");
  pair_33_a: assert property (@(posedge clock) disable iff (sys_rst) // R2
    (instr_valid && instr_addr[2:0] == 3'h3) |=> (cond_code == 2'h3))
    else $error("pair 33/3B accepted");
  route_hi_a: assert property (@(posedge clock) disable iff (sys_rst) // R3
    (start_ok && hi) |=> (bp_start != 8'h00 && lc_start == 8'h00))
    else $error("high address not routed to buffer pool");
  fast_same_a: assert property (@(posedge clock) disable iff (sys_rst) // R4
    (start_ok && instr_op == ppir_pkg::PPIR_OP_START_FAST) |=> (cond_code == 2'h0))
    else $error("fast start not treated as start");
  start_busy_a: assert property (@(posedge clock) disable iff (sys_rst) // R5
    (valid && is_start && cur_busy) |=> (cond_code == 2'h2))
    else $error("busy start not code 2");
  start_reject_a: assert property (@(posedge clock) disable iff (sys_rst) // R6
    (valid && is_start && !cur_busy && !cur_pend && inline_test)
      |=> (cond_code == 2'h1 && status_store))
    else $error("rejected start not code 1");
  test_pend_a: assert property (@(posedge clock) disable iff (sys_rst) // R7
    (valid && is_test && !cur_busy && cur_pend) |=> (cond_code == 2'h1))
    else $error("test with pending not code 1");
  clear_never2_a: assert property (@(posedge clock) disable iff (sys_rst) // R8
    (instr_valid && is_clear) |=> (cond_code != 2'h2 && done))
    else $error("clear gave code 2");
  bp_clear_uc_a: assert property (@(posedge clock) disable iff (sys_rst) // R9
    (valid && hi && is_clear) |=> (port_inactive != 8'h00 && lc_unit_check != 8'h00))
    else $error("buffer pool clear missed unit check");
  halt_never2_a: assert property (@(posedge clock) disable iff (sys_rst) // R10
    (instr_valid && is_halt) |=> (cond_code != 2'h2))
    else $error("halt gave code 2");
  bp_halt_uc_a: assert property (@(posedge clock) disable iff (sys_rst) // R11
    (valid && hi && is_halt) |=> (lc_unit_check == $past(sel_vec)))
    else $error("buffer pool halt missed unit check");
  start_cover: cover property (@(posedge clock) start_ok);
  busy_cover: cover property (@(posedge clock) valid && is_start && cur_busy);
  bp_halt_cover: cover property (@(posedge clock) valid && hi && is_halt);
endmodule // ppir_responder

/* sim/ppir_line_model.sv */
`timescale 1ns/10ps
// behavioural line functions: each start ends DELAY cycles later
module ppir_line_model #(
  parameter int DELAY = 6
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // launches and stops
  input wire logic [7:0] lc_start,
  input wire logic [7:0] bp_start,
  input wire logic [7:0] lc_stop,
  input wire logic [7:0] bp_stop,
  // completions
  output logic [7:0] lc_done,
  output logic [7:0] bp_done
);
  int lc_cnt [8];
  int bp_cnt [8];
  // a stopped function never reports completion
  always @(posedge clock or posedge sys_rst) begin
    for (int i = 0; i < 8; i++) begin
      lc_done[i] <= !sys_rst && lc_cnt[i] == 1;
      bp_done[i] <= !sys_rst && bp_cnt[i] == 1;
      if (sys_rst || lc_stop[i]) lc_cnt[i] <= 0;
      else if (lc_start[i]) lc_cnt[i] <= DELAY;
      else if (lc_cnt[i] != 0) lc_cnt[i] <= lc_cnt[i] - 1;
      if (sys_rst || bp_stop[i]) bp_cnt[i] <= 0;
      else if (bp_start[i]) bp_cnt[i] <= DELAY;
      else if (bp_cnt[i] != 0) bp_cnt[i] <= bp_cnt[i] - 1;
    end
  end
endmodule // ppir_line_model

/* sim/ppir_responder_test.sv */
`timescale 1ns/10ps
module ppir_responder_test;
  localparam ppir_pkg::ppir_op_t ST = ppir_pkg::PPIR_OP_START;
  localparam ppir_pkg::ppir_op_t SF = ppir_pkg::PPIR_OP_START_FAST;
  localparam ppir_pkg::ppir_op_t TS = ppir_pkg::PPIR_OP_TEST;
  localparam ppir_pkg::ppir_op_t CL = ppir_pkg::PPIR_OP_CLEAR;
  localparam ppir_pkg::ppir_op_t HI = ppir_pkg::PPIR_OP_HALT_IO;
  localparam ppir_pkg::ppir_op_t HD = ppir_pkg::PPIR_OP_HALT_DEV;
  logic clock = 0;
  logic sys_rst = 1;
  logic instr_valid = 0;
  logic [3:0] instr_channel = 4'h0;
  logic [7:0] instr_addr = 8'h00;
  ppir_pkg::ppir_op_t instr_op = ST;
  logic noop_no_chain = 0;
  logic cmd_invalid = 0;
  logic inline_test = 0;
  logic [7:0] lc_done, bp_done, lc_start, bp_start, lc_stop, bp_stop;
  logic [7:0] port_inactive, lc_unit_check;
  logic done, claimed, status_store;
  logic [1:0] cond_code;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  initial forever #10 clock = ~clock;
  ppir_responder u_dut (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_channel(instr_channel), .instr_addr(instr_addr), .instr_op(instr_op),
    .noop_no_chain(noop_no_chain), .cmd_invalid(cmd_invalid), .inline_test(inline_test),
    .lc_done(lc_done), .bp_done(bp_done), .done(done), .claimed(claimed),
    .cond_code(cond_code), .status_store(status_store), .lc_start(lc_start),
    .bp_start(bp_start), .lc_stop(lc_stop), .bp_stop(bp_stop),
    .port_inactive(port_inactive), .lc_unit_check(lc_unit_check));
  ppir_line_model u_lines (.clock(clock), .sys_rst(sys_rst), .lc_start(lc_start),
    .bp_start(bp_start), .lc_stop(lc_stop), .bp_stop(bp_stop), .lc_done(lc_done),
    .bp_done(bp_done));
  task chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one instruction; answer judged in its one answer cycle
  task op(logic [3:0] ch, logic [7:0] a, ppir_pkg::ppir_op_t o, logic [1:0] cc, logic cl);
    @(negedge clock);
    instr_valid = 1;
    instr_channel = ch;
    instr_addr = a;
    instr_op = o;
    @(negedge clock);
    instr_valid = 0;
    chk("done", 8'h01, {7'h00, done});
    chk("claimed", {7'h00, cl}, {7'h00, claimed});
    chk("cond_code", {6'h00, cc}, {6'h00, cond_code});
  endtask
  task t_addr;
    op(4'h1, 8'h30, ST, 2'h3, 1'b0);
    op(4'h0, 8'h2F, TS, 2'h3, 1'b0);
    op(4'h0, 8'h40, CL, 2'h3, 1'b0);
    op(4'h0, 8'h33, ST, 2'h3, 1'b1);
    op(4'h0, 8'h3B, HI, 2'h3, 1'b1);
    inline_test = 1;
    op(4'h0, 8'h3B, ST, 2'h3, 1'b1);
    inline_test = 0;
    $display("test addressing finished");
  endtask
  task t_start;
    op(4'h0, 8'h30, ST, 2'h0, 1'b1);
    chk("lc_start", 8'h01, lc_start);
    chk("status_store", 8'h00, {7'h00, status_store});
    op(4'h0, 8'h39, SF, 2'h0, 1'b1);
    chk("bp_start", 8'h02, bp_start);
    op(4'h0, 8'h30, ST, 2'h2, 1'b1);
    op(4'h0, 8'h30, TS, 2'h2, 1'b1);
    repeat (8) @(negedge clock);
    op(4'h0, 8'h30, TS, 2'h1, 1'b1);
    chk("status_store", 8'h01, {7'h00, status_store});
    op(4'h0, 8'h30, TS, 2'h0, 1'b1);
    $display("test start and test finished");
  endtask
  task t_reject;
    noop_no_chain = 1;
    op(4'h0, 8'h32, ST, 2'h1, 1'b1);
    chk("status_store", 8'h01, {7'h00, status_store});
    noop_no_chain = 0;
    cmd_invalid = 1;
    op(4'h0, 8'h32, SF, 2'h1, 1'b1);
    cmd_invalid = 0;
    inline_test = 1;
    op(4'h0, 8'h32, ST, 2'h1, 1'b1);
    inline_test = 0;
    chk("lc_start", 8'h00, lc_start);
    $display("test reject finished");
  endtask
  task t_stop;
    op(4'h0, 8'h34, ST, 2'h0, 1'b1);
    op(4'h0, 8'h34, CL, 2'h1, 1'b1);
    chk("lc_stop", 8'h10, lc_stop);
    chk("status_store", 8'h01, {7'h00, status_store});
    op(4'h0, 8'h36, CL, 2'h0, 1'b1);
    op(4'h0, 8'h35, ST, 2'h0, 1'b1);
    op(4'h0, 8'h35, HI, 2'h1, 1'b1);
    chk("lc_stop", 8'h20, lc_stop);
    chk("port_inactive", 8'h00, port_inactive);
    op(4'h0, 8'h35, HD, 2'h0, 1'b1);
    // buffer pool side takes the whole port down
    op(4'h0, 8'h37, ST, 2'h0, 1'b1);
    op(4'h0, 8'h3F, HD, 2'h0, 1'b1);
    chk("port_inactive", 8'h80, port_inactive);
    chk("lc_unit_check", 8'h80, lc_unit_check);
    chk("bp_stop", 8'h80, bp_stop);
    chk("lc_stop", 8'h80, lc_stop);
    op(4'h0, 8'h37, TS, 2'h0, 1'b1);
    op(4'h0, 8'h3E, CL, 2'h0, 1'b1);
    chk("port_inactive", 8'h40, port_inactive);
    chk("lc_unit_check", 8'h40, lc_unit_check);
    chk("bp_stop", 8'h40, bp_stop);
    $display("test clear and halt finished");
  endtask
  // reset in mid-run drops a running function
  task t_reset;
    op(4'h0, 8'h31, ST, 2'h0, 1'b1);
    @(negedge clock);
    sys_rst = 1;
    @(negedge clock);
    sys_rst = 0;
    chk("done", 8'h00, {7'h00, done});
    chk("cond_code", 8'h00, {6'h00, cond_code});
    op(4'h0, 8'h31, TS, 2'h0, 1'b1);
    $display("test reset finished");
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // whole run needs well under 200 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    sys_rst = 0;
    t_addr;
    t_start;
    t_reject;
    t_stop;
    t_reset;
    finish_test;
  end
endmodule // ppir_responder_test
